// ==== rtl/iefrs_pkg.sv ====
/*
 * Shared constants for the interrupt enable and flag block: register
 * offsets, bit positions, reset values and mode encodings.
 * Assumes a 32-bit APB with byte addresses, one word per register.
 */
package iefrs_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_ICTL = 8'h00;
	localparam logic [7:0] OFS_PEN = 8'h04;
	localparam logic [7:0] OFS_PFLG = 8'h08;
	localparam logic [7:0] OFS_PWR = 8'h0C;
	localparam logic [7:0] OFS_PPIN = 8'h10;
	localparam logic [7:0] OFS_CFG = 8'h14;

	// Register select codes
	localparam logic [2:0] SEL_ICTL = 3'h0;
	localparam logic [2:0] SEL_PEN = 3'h1;
	localparam logic [2:0] SEL_PFLG = 3'h2;
	localparam logic [2:0] SEL_PWR = 3'h3;
	localparam logic [2:0] SEL_PPIN = 3'h4;
	localparam logic [2:0] SEL_CFG = 3'h5;
	localparam logic [2:0] SEL_NONE = 3'h7;

	// interrupt_control fields
	localparam int ICTL_GIE = 7;
	localparam int ICTL_PGE = 6;
	localparam int ICTL_T0E = 5;
	localparam int ICTL_EXE = 4;
	localparam int ICTL_PCE = 3;
	localparam int ICTL_T0F = 2;
	localparam int ICTL_EXF = 1;
	localparam int ICTL_PCF = 0;

	// Peripheral enable and flag positions
	localparam int PB_NV = 7;
	localparam int PB_ADC = 6;
	localparam int PB_CC = 5;
	localparam int PB_CB = 4;
	localparam int PB_CA = 3;
	localparam int PB_OSC = 2;
	localparam int PB_T2 = 1;
	localparam int PB_T1 = 0;

	// power_reset_status fields
	localparam int PWR_SBO = 4;
	localparam int PWR_POR = 1;
	localparam int PWR_BOR = 0;

	// Configuration register fields
	localparam int CFG_EDGE = 0;
	localparam int CFG_BOM = 1;

	// Reset values
	localparam logic [7:0] ICTL_RST = 8'h00;
	localparam logic [7:0] PEN_RST = 8'h00;
	localparam logic [7:0] PFLG_RST = 8'h00;
	localparam logic [5:0] PPIN_RST = 6'h00;
	localparam logic [2:0] CFG_RST = 3'h3;
	localparam logic SBO_RST = 1'b1;

	// Synchronised inputs
	localparam int PIN_W = 6;
	localparam int SYNC_W = 9;
	localparam int SY_EXT = 0;
	localparam int SY_PORT = 1;
	localparam int SY_CA = 7;
	localparam int SY_CB = 8;
	localparam logic [1:0] SYNC_WARM = 2'h3;

	typedef enum logic [1:0] {
		CC_OFF = 2'b00,
		CC_CAPTURE = 2'b01,
		CC_COMPARE = 2'b10,
		CC_PWM = 2'b11
	} iefrs_ccmode_t;

	typedef enum logic [1:0] {
		BOM_OFF = 2'b00,
		BOM_SW = 2'b01,
		BOM_RUN = 2'b10,
		BOM_ON = 2'b11
	} iefrs_bom_t;

	typedef enum logic {
		AP_IDLE = 1'b0,
		AP_ACK = 1'b1
	} iefrs_apb_t;

endpackage

// ==== rtl/iefrs_sync.sv ====
/*
 * Three-stage synchroniser with agreement filter for pin-level inputs.
 * Assumes raw inputs are asynchronous to clk; outputs are on clk.
 */
`timescale 1ns/10ps
module iefrs_sync
	import iefrs_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Raw pins
	input wire logic [SYNC_W-1:0] raw,
	// Filtered result
	iefrs_sync_if.src sy
);

	logic [SYNC_W-1:0] s1;
	logic [SYNC_W-1:0] s2;
	logic [SYNC_W-1:0] s3;
	logic [SYNC_W-1:0] agree;
	logic [1:0] warm;

	assign agree = ~(s2 ^ s3);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else if (ce) begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Pipe fill takes the pin state as baseline, no change pulse
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			warm <= 2'h0;
			sy.level <= '0;
			sy.change <= '0;
		end else if (ce) begin
			if (warm != SYNC_WARM) begin
				warm <= warm + 2'h1;
				sy.level <= s2;
				sy.change <= '0;
			end else begin
				sy.level <= (s2 & agree) | (sy.level & ~agree);
				sy.change <= agree & (s2 ^ sy.level);
			end
		end else begin
			sy.change <= '0;
		end
	end

endmodule

// ==== rtl/iefrs_sync_if.sv ====
/*
 * Carrier between the pin synchroniser and the flag logic: filtered
 * levels and one-cycle change pulses.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/10ps
interface iefrs_sync_if
	import iefrs_pkg::*;
	();
	logic [SYNC_W-1:0] level;
	logic [SYNC_W-1:0] change;
	modport src(output level, output change);
	modport dst(input level, input change);
endinterface

// ==== rtl/iefrs_top.sv ====
/*
 * Interrupt enable and flag logic with reset-status bits and the
 * software brown-out enable, reached over a 32-bit APB slave.
 * Assumes event pulses other than pins and comparators come from logic
 * on SYS_CLK; reset-cause inputs come from the reset controller.
 */
//
// Behaviour
// - Flags set on their event whatever the enables hold.
// - Global enable bit 7 passes unmasked requests, blocks all when 0.
// - Group enable bit 6 must be 1 for peripheral requests.
// - Timer0 overflow flag bit 2, gated by enable bit 5.
// - External pin flag bit 1 on selected edge, enable bit 4.
// - Port-change flag bit 0 on any change of pins 5..0.
// - Port-change request needs enable bit and per-pin enables.
// - Peripheral enables in fixed order bit 7..0, reset 0.
// - Peripheral flags share enable positions, reset 0, read/write.
// - Nonvolatile write flag bit 7 set on completion, sticky.
// - Converter flag bit 6 set on finished conversion, sticky.
// - Capture/compare flag bit 5 by mode; ignored in PWM mode.
// - Comparator flags bits 4 and 3 set on output change.
// - Oscillator fail flag bit 2 on failover to internal oscillator.
// - Timer2 match flag bit 1, timer1 overflow flag bit 0.
// - Power-on clears status bit 1; software writes it to 1.
// - Brown-out clears status bit 0; software writes it to 1.
// - Software brown-out enable acts only when config mode is 01.
// - Unimplemented power-control bits read 0, ignore writes.
`timescale 1ns/10ps
module iefrs_top
	import iefrs_pkg::*;
(
	// Clock, reset, enable
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic CE,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Core event sources
	input wire logic TIMER0_OVF,
	input wire logic EXT_IRQ_PIN,
	input wire logic [5:0] PORT_A_PINS,
	// Peripheral event sources
	input wire logic NV_WRITE_DONE,
	input wire logic CONVERSION_DONE,
	input wire logic CAPCMP_CAPTURE,
	input wire logic CAPCMP_COMPARE,
	input wire logic [1:0] CAPCMP_MODE,
	input wire logic COMPARATOR_A_OUT,
	input wire logic COMPARATOR_B_OUT,
	input wire logic OSC_FAIL,
	input wire logic TIMER2_MATCH,
	input wire logic TIMER1_OVF,
	// Reset causes
	input wire logic POWER_ON_RESET,
	input wire logic BROWNOUT_RESET,
	// Results
	output logic IRQ,
	output logic BROWNOUT_DETECT_EN
);

	iefrs_sync_if sy();

	iefrs_apb_t apb_state;
	iefrs_apb_t next_apb_state;
	iefrs_ccmode_t cc_mode;
	iefrs_bom_t bo_mode;

	logic [7:0] interrupt_control;
	logic [7:0] peripheral_irq_enables;
	logic [7:0] peripheral_irq_flags;
	logic [5:0] per_pin_change_enables;
	logic [2:0] config_reg;
	logic sw_brownout_enable;
	logic power_on_flag;
	logic brownout_reset_flag;

	logic [2:0] rd_sel;
	logic [2:0] wr_sel;
	logic [7:0] rd_byte;
	logic [7:0] wd;
	logic [7:0] core_set;
	logic [7:0] periph_set;
	logic access_done;
	logic wr_en;
	logic wr_ictl;
	logic wr_pen;
	logic wr_pflg;
	logic wr_pwr;
	logic wr_ppin;
	logic wr_cfg;
	logic ext_edge;
	logic port_change;
	logic capcmp_hit;
	logic core_pend;
	logic periph_pend;
	logic next_irq;
	logic next_bo_en;

	// Map a byte address to a register select code
	function automatic logic [2:0] reg_sel(input logic [7:0] addr);
		case (addr)
			OFS_ICTL: reg_sel = SEL_ICTL;
			OFS_PEN: reg_sel = SEL_PEN;
			OFS_PFLG: reg_sel = SEL_PFLG;
			OFS_PWR: reg_sel = SEL_PWR;
			OFS_PPIN: reg_sel = SEL_PPIN;
			OFS_CFG: reg_sel = SEL_CFG;
			default: reg_sel = SEL_NONE;
		endcase
	endfunction

	// Write merge where a hardware set always beats software
	function automatic logic [7:0] merge(
		input logic [7:0] old,
		input logic wr,
		input logic [7:0] wval,
		input logic [7:0] setv
	);
		merge = (wr ? wval : old) | setv;
	endfunction

	iefrs_sync u_sync (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.ce(CE),
		.raw({COMPARATOR_B_OUT, COMPARATOR_A_OUT, PORT_A_PINS, EXT_IRQ_PIN}),
		.sy(sy.src)
	);

	assign cc_mode = iefrs_ccmode_t'(CAPCMP_MODE);
	assign bo_mode = iefrs_bom_t'(config_reg[CFG_BOM+1:CFG_BOM]);

	// Bus decode
	assign rd_sel = reg_sel(PADDR);
	assign wr_sel = reg_sel(PADDR);
	assign wd = PWDATA[7:0];
	assign access_done = (apb_state == AP_ACK) && PSEL && PENABLE;
	assign wr_en = access_done && PWRITE && PSTRB[0];
	assign wr_ictl = wr_en && (wr_sel == SEL_ICTL);
	assign wr_pen = wr_en && (wr_sel == SEL_PEN);
	assign wr_pflg = wr_en && (wr_sel == SEL_PFLG);
	assign wr_pwr = wr_en && (wr_sel == SEL_PWR);
	assign wr_ppin = wr_en && (wr_sel == SEL_PPIN);
	assign wr_cfg = wr_en && (wr_sel == SEL_CFG);

	// Event detection
	assign ext_edge = sy.change[SY_EXT] &&
		(sy.level[SY_EXT] == config_reg[CFG_EDGE]);
	assign port_change = |sy.change[SY_PORT+PIN_W-1:SY_PORT];
	assign capcmp_hit = ((cc_mode == CC_CAPTURE) && CAPCMP_CAPTURE) ||
		((cc_mode == CC_COMPARE) && CAPCMP_COMPARE);

	always_comb begin
		core_set = 8'h00;
		core_set[ICTL_T0F] = TIMER0_OVF;
		core_set[ICTL_EXF] = ext_edge;
		core_set[ICTL_PCF] = port_change;
	end

	always_comb begin
		periph_set = 8'h00;
		periph_set[PB_NV] = NV_WRITE_DONE;
		periph_set[PB_ADC] = CONVERSION_DONE;
		periph_set[PB_CC] = capcmp_hit;
		periph_set[PB_CB] = sy.change[SY_CB];
		periph_set[PB_CA] = sy.change[SY_CA];
		periph_set[PB_OSC] = OSC_FAIL;
		periph_set[PB_T2] = TIMER2_MATCH;
		periph_set[PB_T1] = TIMER1_OVF;
	end

	// Read mux
	always_comb begin
		rd_byte = 8'h00;
		case (rd_sel)
			SEL_ICTL: rd_byte = interrupt_control;
			SEL_PEN: rd_byte = peripheral_irq_enables;
			SEL_PFLG: rd_byte = peripheral_irq_flags;
			SEL_PWR: begin
				rd_byte[PWR_SBO] = sw_brownout_enable;
				rd_byte[PWR_POR] = power_on_flag;
				rd_byte[PWR_BOR] = brownout_reset_flag;
			end
			SEL_PPIN: rd_byte = {2'h0, per_pin_change_enables};
			SEL_CFG: rd_byte = {5'h00, config_reg};
			default: rd_byte = 8'h00;
		endcase
	end

	// Bus state machine: one wait state per transfer
	always_comb begin
		next_apb_state = apb_state;
		case (apb_state)
			AP_IDLE: begin
				if (PSEL && PENABLE) begin
					next_apb_state = AP_ACK;
				end
			end
			AP_ACK: begin
				next_apb_state = AP_IDLE;
			end
			default: begin
				next_apb_state = AP_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			apb_state <= AP_IDLE;
		end else if (CE) begin
			apb_state <= next_apb_state;
		end
	end

	// Answer registers
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			PREADY <= 1'b0;
			PRDATA <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else if (CE) begin
			if (apb_state == AP_IDLE && PSEL && PENABLE) begin
				PREADY <= 1'b1;
				PSLVERR <= (rd_sel == SEL_NONE);
				PRDATA <= PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_byte};
			end else begin
				PREADY <= 1'b0;
				PSLVERR <= 1'b0;
				PRDATA <= 32'h0000_0000;
			end
		end
	end

	// Interrupt control: enables plain, flags sticky
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			interrupt_control <= ICTL_RST;
		end else if (CE) begin
			interrupt_control <= merge(interrupt_control, wr_ictl, wd, core_set);
		end
	end

	// Peripheral enables
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			peripheral_irq_enables <= PEN_RST;
		end else if (CE && wr_pen) begin
			peripheral_irq_enables <= wd;
		end
	end

	// Peripheral flags, cleared only by RST_N or a software write
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			peripheral_irq_flags <= PFLG_RST;
		end else if (CE) begin
			peripheral_irq_flags <= merge(peripheral_irq_flags, wr_pflg, wd, periph_set);
		end
	end

	// Per-pin change enables
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			per_pin_change_enables <= PPIN_RST;
		end else if (CE && wr_ppin) begin
			per_pin_change_enables <= wd[PIN_W-1:0];
		end
	end

	// Edge select and brown-out mode
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			config_reg <= CFG_RST;
		end else if (CE && wr_cfg) begin
			config_reg <= wd[2:0];
		end
	end

	// Software brown-out enable; only bit 4 of the word is kept
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			sw_brownout_enable <= SBO_RST;
		end else if (CE && wr_pwr) begin
			sw_brownout_enable <= wd[PWR_SBO];
		end
	end

	// Reset-status bits survive RST_N; the reset cause wins over software
	always_ff @(posedge SYS_CLK) begin
		if (POWER_ON_RESET) begin
			power_on_flag <= 1'b0;
		end else if (CE && wr_pwr) begin
			power_on_flag <= wd[PWR_POR];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (BROWNOUT_RESET) begin
			brownout_reset_flag <= 1'b0;
		end else if (CE && wr_pwr) begin
			brownout_reset_flag <= wd[PWR_BOR];
		end
	end

	// Request combining
	always_comb begin
		core_pend = (interrupt_control[ICTL_T0E] && interrupt_control[ICTL_T0F]) ||
			(interrupt_control[ICTL_EXE] && interrupt_control[ICTL_EXF]) ||
			(interrupt_control[ICTL_PCE] && (|per_pin_change_enables) &&
			interrupt_control[ICTL_PCF]);
		periph_pend = interrupt_control[ICTL_PGE] &&
			(|(peripheral_irq_enables & peripheral_irq_flags));
		next_irq = interrupt_control[ICTL_GIE] && (core_pend || periph_pend);
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			IRQ <= 1'b0;
		end else if (CE) begin
			IRQ <= next_irq;
		end
	end

	// Brown-out detector enable by configured mode
	always_comb begin
		case (bo_mode)
			BOM_OFF: next_bo_en = 1'b0;
			BOM_SW: next_bo_en = sw_brownout_enable;
			BOM_RUN: next_bo_en = 1'b1;
			BOM_ON: next_bo_en = 1'b1;
			default: next_bo_en = 1'b0;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			BROWNOUT_DETECT_EN <= 1'b0;
		end else if (CE) begin
			BROWNOUT_DETECT_EN <= next_bo_en;
		end
	end

endmodule

// ==== verif/iefrs_chk_sva.sv ====
/*
 * Port checker for iefrs_top, with shadows of software-written bits.
 * Assumes the APB master holds each request until PREADY, CE high.
 */
`timescale 1ns/10ps
module iefrs_chk
	import iefrs_pkg::*;
(
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic CE,
	// APB
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	// Events and results
	input wire logic TIMER1_OVF,
	input wire logic IRQ,
	input wire logic BROWNOUT_DETECT_EN
);
	logic [7:0] ictl;
	logic [1:0] mode;
	logic sbo;
	logic en1;
	logic bo;
	logic wr;
	assign wr = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
	assign bo = mode[1] || (mode == BOM_SW && sbo);
	// Shadow of what software last wrote
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			ictl <= ICTL_RST;
			mode <= CFG_RST[2:1];
			sbo <= SBO_RST;
			en1 <= 1'b0;
		end else if (wr) begin
			if (PADDR == OFS_ICTL)
				ictl <= PWDATA[7:0];
			if (PADDR == OFS_CFG)
				mode <= PWDATA[2:1];
			if (PADDR == OFS_PWR)
				sbo <= PWDATA[PWR_SBO];
			if (PADDR == OFS_PEN)
				en1 <= PWDATA[PB_T1];
		end
	end
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	AST_ACK_ONE_WAIT: assert property ($rose(PENABLE) && PSEL && CE |=> PREADY)
		else $error("ready missing after one wait state");
	AST_ACK_PULSE: assert property (PREADY |=> !PREADY)
		else $error("ready held longer than one cycle");
	AST_GIE_BLOCKS: assert property (!ictl[ICTL_GIE] |=> !IRQ)
		else $error("request with global enable off");
	AST_GROUP_BLOCKS: assert property (ictl[7] && !ictl[6] && ictl[5:3] == 3'h0 |=> !IRQ)
		else $error("peripheral request with group enable off");
	AST_PWR_UNUSED_ZERO: assert property (PREADY && PSEL && !PWRITE && PADDR == OFS_PWR
		|-> PRDATA[7:5] == 3'h0 && PRDATA[3:2] == 2'h0)
		else $error("unused power bits read nonzero");
	AST_BO_ON: assert property (bo [*3] |-> BROWNOUT_DETECT_EN)
		else $error("brownout detect off when selected on");
	AST_BO_OFF: assert property ((!bo) [*3] |-> !BROWNOUT_DETECT_EN)
		else $error("brownout detect on when selected off");
	AST_T1_RAISES_IRQ: assert property (ictl[7] && ictl[6] && en1 && TIMER1_OVF |-> ##2 IRQ)
		else $error("timer1 event did not raise request");
endmodule
bind iefrs_top iefrs_chk chk_u (.SYS_CLK, .RST_N, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR,
	.PWDATA, .PSTRB, .PRDATA, .PREADY, .TIMER1_OVF, .IRQ, .BROWNOUT_DETECT_EN);

// ==== verif/iefrs_evt_model.sv ====
/*
 * Event source model: one-cycle event pulses and comparator levels.
 * Assumes requests come from the bench on the system clock.
 */
`timescale 1ns/10ps
module iefrs_evt_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Requests
	input wire logic [11:0] req,
	// Events
	output logic [11:0] pulse,
	output logic [1:0] cmp
);
	// Single-cycle events, reset causes
	always_ff @(posedge clk) begin
		pulse <= req;
	end
	// Comparator outputs toggle on request
	always_ff @(posedge clk) begin
		if (!rst_n)
			cmp <= 2'h0;
		else
			cmp <= cmp ^ req[4:3];
	end
endmodule

// ==== verif/testbench.sv ====
/*
 * Self-checking bench for iefrs_top: registers over APB, events from
 * the source model, random enable and event mixes.
 * Assumes the checker is bound in from its own file.
 */
`timescale 1ns/10ps
module testbench
	import iefrs_pkg::*;
;
	logic SYS_CLK, RST_N, psel, pena, pwr, ext, irq, bde, prdy, perr, ce;
	logic [3:0] pstrb;
	logic [7:0] paddr;
	logic [31:0] pwd, prd, r;
	logic [11:0] req, pulse;
	logic [5:0] pins;
	logic [1:0] ccm, cmp;
	integer seed, err_count, tests_run, i;
	integer cyc = 0;
	always #50 SYS_CLK = ~SYS_CLK;
	iefrs_evt_model src_u (.clk(SYS_CLK), .rst_n(RST_N), .req(req), .pulse(pulse), .cmp(cmp));
	iefrs_top dut_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CE(ce), .PSEL(psel), .PENABLE(pena),
		.PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd), .PSTRB(pstrb), .PRDATA(prd), .PREADY(prdy),
		.PSLVERR(perr), .TIMER0_OVF(pulse[9]), .EXT_IRQ_PIN(ext), .PORT_A_PINS(pins),
		.NV_WRITE_DONE(pulse[7]), .CONVERSION_DONE(pulse[6]), .CAPCMP_CAPTURE(pulse[5]),
		.CAPCMP_COMPARE(pulse[8]), .CAPCMP_MODE(ccm), .COMPARATOR_A_OUT(cmp[0]),
		.COMPARATOR_B_OUT(cmp[1]), .OSC_FAIL(pulse[2]), .TIMER2_MATCH(pulse[1]),
		.TIMER1_OVF(pulse[0]), .POWER_ON_RESET(pulse[10]), .BROWNOUT_RESET(pulse[11]),
		.IRQ(irq), .BROWNOUT_DETECT_EN(bde));
	function automatic logic exp_irq(input logic [7:0] ic, input logic [7:0] en,
		input logic [7:0] fl);
		return ic[7] && ic[6] && (|(en & fl));
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string n);
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("unexpected %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] q, output logic e);
		@(posedge SYS_CLK);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwd <= {24'h0, d};
		@(posedge SYS_CLK);
		pena <= 1'b1;
		do @(posedge SYS_CLK); while (prdy !== 1'b1);
		q = prd;
		e = perr;
		psel <= 1'b0;
		pena <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] x, input string n);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 8'h00, q, e);
		chk(q, {24'h0, x}, n);
	endtask
	task automatic fire(input logic [11:0] f);
		@(posedge SYS_CLK);
		req <= f;
		@(posedge SYS_CLK);
		req <= 12'h000;
		repeat (8) @(posedge SYS_CLK);
	endtask
	task automatic cbit(input logic s, input logic x, input string n);
		chk({31'h0, s}, {31'h0, x}, n);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge SYS_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count = err_count + 1;
			test_done;
		end
	end
	initial begin
		logic [31:0] q;
		logic e;
		seed = 32'h97FE;
		err_count = 0;
		tests_run = 0;
		SYS_CLK = 1'b0;
		RST_N = 1'b0;
		psel = 1'b0;
		pena = 1'b0;
		pwr = 1'b0;
		paddr = 8'h00;
		pwd = 32'h0;
		ext = 1'b0;
		pins = 6'h00;
		ce = 1'b1;
		pstrb = 4'hF;
		ccm = CC_CAPTURE;
		req = 12'hC00;
		repeat (12) @(posedge SYS_CLK);
		req <= 12'h000;
		repeat (4) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		rdc(OFS_ICTL, 8'h00, "ictl reset");
		rdc(OFS_PEN, 8'h00, "enables reset");
		rdc(OFS_PFLG, 8'h00, "flags reset");
		rdc(OFS_PWR, 8'h10, "power reset");
		wr(OFS_PWR, 8'hFF);
		rdc(OFS_PWR, 8'h13, "power written");
		fire(12'h800);
		rdc(OFS_PWR, 8'h12, "brownout status");
		apb(1'b0, 8'h18, 8'h00, q, e);
		chk(q, 32'h0, "unmapped data");
		cbit(e, 1'b1, "unmapped error");
		pstrb <= 4'h0;
		wr(OFS_PEN, 8'hFF);
		pstrb <= 4'hF;
		rdc(OFS_PEN, 8'h00, "strobe off write");
		ce <= 1'b0;
		fire(12'h001);
		ce <= 1'b1;
		rdc(OFS_PFLG, 8'h00, "frozen flags");
		$display("test reset and power done");
		for (i = 0; i < 8; i++) begin
			wr(OFS_PWR, {3'h0, i[0], 4'h3});
			wr(OFS_CFG, {5'h0, i[2:1], 1'b1});
			repeat (3) @(posedge SYS_CLK);
			cbit(bde, i[2] || (i[2:1] == 2'b01 && i[0]), "brownout enable");
		end
		$display("test brownout done");
		for (i = 0; i < 6; i++) begin
			r = (i == 0) ? 32'h0003FFFF : (i == 1) ? 32'h0002FFFF : $random(seed);
			wr(OFS_PFLG, 8'h00);
			wr(OFS_PEN, r[15:8]);
			wr(OFS_ICTL, {r[17:16], 6'h00});
			fire({4'h0, r[7:0]});
			rdc(OFS_PFLG, r[7:0], "flags");
			cbit(irq, exp_irq({r[17:16], 6'h00}, r[15:8], r[7:0]), "irq");
			repeat (20) @(posedge SYS_CLK);
			rdc(OFS_PFLG, r[7:0], "sticky flags");
		end
		$display("test peripheral flags done");
		for (i = 0; i < 4; i++) begin
			ccm <= i[1:0];
			wr(OFS_PFLG, 8'h00);
			fire(i == 1 ? 12'h020 : i == 2 ? 12'h100 : 12'h120);
			rdc(OFS_PFLG, (i == 0 || i == 3) ? 8'h00 : 8'h20, "capcmp mode");
		end
		$display("test capcmp done");
		wr(OFS_ICTL, 8'h00);
		fire(12'h200);
		rdc(OFS_ICTL, 8'h04, "timer0 flag");
		ext <= 1'b1;
		repeat (8) @(posedge SYS_CLK);
		rdc(OFS_ICTL, 8'h06, "ext flag");
		pins <= 6'h20;
		repeat (8) @(posedge SYS_CLK);
		rdc(OFS_ICTL, 8'h07, "port flag");
		wr(OFS_ICTL, 8'hA4);
		repeat (3) @(posedge SYS_CLK);
		cbit(irq, 1'b1, "timer0 irq");
		wr(OFS_ICTL, 8'h24);
		repeat (3) @(posedge SYS_CLK);
		cbit(irq, 1'b0, "global off");
		wr(OFS_ICTL, 8'h89);
		repeat (3) @(posedge SYS_CLK);
		cbit(irq, 1'b0, "no per-pin enable");
		wr(OFS_PPIN, 8'h01);
		repeat (3) @(posedge SYS_CLK);
		cbit(irq, 1'b1, "port irq");
		$display("test core flags done");
		wr(OFS_CFG, 8'h06);
		ext <= 1'b0;
		repeat (8) @(posedge SYS_CLK);
		rdc(OFS_ICTL, 8'h8B, "falling edge flag");
		RST_N <= 1'b0;
		repeat (2) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		repeat (8) @(posedge SYS_CLK);
		rdc(OFS_ICTL, 8'h00, "no flag after reset");
		rdc(OFS_PFLG, 8'h00, "no change after reset");
		rdc(OFS_PWR, 8'h13, "status kept");
		$display("test edge and second reset done");
		test_done;
	end
endmodule
